// *** tmpe_decoder_model.sv ***
// Far-side time mark receiver: counts mark starts and the length of the current mark.
// Assumes the mark line is a clean logic level on the device clock.
`timescale 1ns/1ps
module tmpe_decoder_model (
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  // Time mark line
  input  wire logic  mark_in,
  // Observations
  output int unsigned rise_count_out,
  output int unsigned high_len_out
);
  logic mark_d_r;

  // High level is the asserted mark; a rise starts a second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mark_d_r       <= 1'b0;
      high_len_out   <= 0;
      rise_count_out <= 0;
    end else begin
      mark_d_r       <= mark_in;
      high_len_out   <= mark_in ? high_len_out + 1 : 0;
      if (mark_in && !mark_d_r) begin
        rise_count_out <= rise_count_out + 1;
      end
    end
  end
endmodule

// *** tmpe_encoder.sv ***
// Time mark pulse encoder: one pulse-width-coded mark per second except second 59, one frame per minute.
// Assumes pps_in and time_in come from logic on clk_in; pps_in is a one-cycle pulse.
//
// Contract
// - The mark output is a plain logic level, high while a mark is asserted.
// - Each mark starts in the cycle after the second boundary pulse.
// - A zero bit gives a mark 100 ms long.
// - A one bit gives a mark 200 ms long.
// - Seconds 15 to 58 carry date, time, parity and status bits.
// - Second 59 carries no mark so the next mark starts a minute.
// - The whole time is sent once per minute with BCD fields.
// - The frame carries the configured local time plus DST and leap second warnings.
// - The output works from reset release with no sync wait.
`timescale 1ns/1ps
module tmpe_encoder (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Timing frame
  input  wire logic              pps_in,
  input  wire logic [5:0]        sec_in,
  // Local time of the coming minute
  input  wire tmpe_pkg::tmpe_time_t time_in,
  // Status
  output logic                   frame_ready_out,
  output logic                   frame_lost_out,
  // Time mark line
  output logic                   mark_out
);

  localparam int unsigned W = tmpe_pkg::FRAME_W;

  tmpe_pkg::tmpe_state_t state_r;
  tmpe_pkg::tmpe_state_t state_nxt;
  logic [tmpe_pkg::CNT_W-1:0] cnt_r;
  logic [tmpe_pkg::CNT_W-1:0] cnt_nxt;
  logic [tmpe_pkg::CNT_W-1:0] len_r;
  logic [tmpe_pkg::CNT_W-1:0] len_nxt;
  logic [W-1:0]               cur_r;
  logic [W-1:0]               cur_nxt;
  logic                       mark_nxt;
  logic                       lost_r;
  logic                       lost_nxt;
  logic [W-1:0]               frame;
  logic                       push;
  logic                       wr_ready;
  logic                       rd_valid;
  logic [W-1:0]               rd_data;
  logic                       pop;
  logic                       bit_now;

  // Build the minute frame from the unlatched time_in input; the queue captures it at second 58
  always_comb begin
    frame = '0;
    frame[tmpe_pkg::POS_CALLBIT]  = time_in.call_bit;
    frame[tmpe_pkg::POS_DST_ANN]  = time_in.dst_ann;
    frame[tmpe_pkg::POS_DST_SUM]  = time_in.dst_on;
    frame[tmpe_pkg::POS_DST_WIN]  = !time_in.dst_on;
    frame[tmpe_pkg::POS_LEAP_ANN] = time_in.leap_ann;
    frame[tmpe_pkg::POS_TIME_ST]  = 1'b1;
    frame[tmpe_pkg::POS_MIN +: 7]  = time_in.minute;
    frame[tmpe_pkg::POS_MIN_PAR]   = ^time_in.minute;
    frame[tmpe_pkg::POS_HOUR +: 6] = time_in.hour;
    frame[tmpe_pkg::POS_HOUR_PAR]  = ^time_in.hour;
    frame[tmpe_pkg::POS_DAY +: 6]  = time_in.day;
    frame[tmpe_pkg::POS_WDAY +: 3] = time_in.wday;
    frame[tmpe_pkg::POS_MON +: 5]  = time_in.month;
    frame[tmpe_pkg::POS_YEAR +: 8] = time_in.year;
    frame[tmpe_pkg::POS_DATE_PAR]  = ^{time_in.day, time_in.wday, time_in.month,
                                       time_in.year};
  end

  // Next minute is queued during second 58, ahead of second zero
  assign push = pps_in && (sec_in == tmpe_pkg::SEC_LATCH);
  // Frame becomes current at the gap second so second zero already uses it
  assign pop  = pps_in && (sec_in == tmpe_pkg::SEC_GAP) && rd_valid;

  tmpe_fifo #(
    .WIDTH (W),
    .DEPTH (tmpe_pkg::FIFO_DEPTH),
    .AW    (tmpe_pkg::FIFO_AW)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .wr_valid_in  (push),
    .wr_data_in   (frame),
    .wr_ready_out (wr_ready),
    .rd_valid_out (rd_valid),
    .rd_data_out  (rd_data),
    .rd_ready_in  (pop)
  );

  always_comb begin
    bit_now = cur_r[sec_in];
  end

  // Mark timing
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    len_nxt   = len_r;
    mark_nxt  = 1'b0;
    cur_nxt   = pop ? rd_data : cur_r;
    lost_nxt  = lost_r || (push && !wr_ready);
    unique case (state_r)
      tmpe_pkg::TMPE_IDLE: begin
        // Second 59 stays silent to flag the minute boundary
        if (pps_in && sec_in != tmpe_pkg::SEC_GAP) begin
          state_nxt = tmpe_pkg::TMPE_MARK;
          cnt_nxt   = '0;
          len_nxt   = bit_now ? tmpe_pkg::CNT_W'(tmpe_pkg::MARK1_CYC)
                              : tmpe_pkg::CNT_W'(tmpe_pkg::MARK0_CYC);
          mark_nxt  = 1'b1;
        end
      end
      tmpe_pkg::TMPE_MARK: begin
        if (cnt_r == len_r - 1'b1) begin
          state_nxt = tmpe_pkg::TMPE_IDLE;
          mark_nxt  = 1'b0;
        end else begin
          cnt_nxt  = cnt_r + 1'b1;
          mark_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = tmpe_pkg::TMPE_IDLE;
      end
    endcase
  end

  // No sync gate: active from reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r  <= tmpe_pkg::TMPE_IDLE;
      cnt_r    <= '0;
      len_r    <= '0;
      cur_r    <= '0;
      lost_r   <= 1'b0;
      mark_out <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      len_r    <= len_nxt;
      cur_r    <= cur_nxt;
      lost_r   <= lost_nxt;
      mark_out <= mark_nxt;
    end
  end

  assign frame_ready_out = rd_valid;
  assign frame_lost_out  = lost_r;

  // Check helper: marks last millions of cycles, far beyond any delay a property may hold
  logic [tmpe_pkg::CNT_W-1:0] hi_cnt_r;
  logic [tmpe_pkg::CNT_W-1:0] hi_cnt_nxt;

  always_comb begin
    hi_cnt_nxt = mark_out ? hi_cnt_r + 1'b1 : '0;
  end

  // Count trails the line by one cycle, so a fall sees the full mark length
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi_cnt_r <= '0;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
    end
  end

  chk_mark_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pps_in && sec_in != tmpe_pkg::SEC_GAP && state_r == tmpe_pkg::TMPE_IDLE) |=> mark_out)
    else $error("mark did not start at second boundary");

  chk_gap_silent: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pps_in && sec_in == tmpe_pkg::SEC_GAP && state_r == tmpe_pkg::TMPE_IDLE) |=> !mark_out)
    else $error("mark sent in gap second");

  chk_zero_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($fell(mark_out) && len_r == tmpe_pkg::CNT_W'(tmpe_pkg::MARK0_CYC))
      |-> hi_cnt_r == tmpe_pkg::CNT_W'(tmpe_pkg::MARK0_CYC - 1))
    else $error("zero mark length wrong");

  chk_one_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($fell(mark_out) && len_r == tmpe_pkg::CNT_W'(tmpe_pkg::MARK1_CYC))
      |-> hi_cnt_r == tmpe_pkg::CNT_W'(tmpe_pkg::MARK1_CYC - 1))
    else $error("one mark length wrong");

  chk_len_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pps_in && state_r == tmpe_pkg::TMPE_IDLE && sec_in != tmpe_pkg::SEC_GAP)
      |=> len_r == (cur_r[$past(sec_in)] ? tmpe_pkg::CNT_W'(tmpe_pkg::MARK1_CYC)
                                          : tmpe_pkg::CNT_W'(tmpe_pkg::MARK0_CYC)))
    else $error("mark length does not follow frame bit");

  chk_min_parity: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ^frame[tmpe_pkg::POS_MIN_PAR:tmpe_pkg::POS_MIN] == 1'b0)
    else $error("minute parity odd");

  chk_hour_parity: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ^frame[tmpe_pkg::POS_HOUR_PAR:tmpe_pkg::POS_HOUR] == 1'b0)
    else $error("hour parity odd");

  chk_date_parity: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ^frame[tmpe_pkg::POS_DATE_PAR:tmpe_pkg::POS_DAY] == 1'b0)
    else $error("date parity odd");

  chk_frame_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pop |=> cur_r == $past(rd_data))
    else $error("frame not taken at gap second");

  chk_dst_pair: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame[tmpe_pkg::POS_DST_SUM] != frame[tmpe_pkg::POS_DST_WIN])
    else $error("dst bits not complementary");

  chk_mark_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mark_out == (state_r == tmpe_pkg::TMPE_MARK))
    else $error("mark level does not match state");

  chk_mark_refused: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pps_in && state_r == tmpe_pkg::TMPE_MARK && cnt_r != len_r - 1'b1)
      |=> (state_r == tmpe_pkg::TMPE_MARK && cnt_r == $past(cnt_r) + 1'b1))
    else $error("second boundary restarted a running mark");

  chk_start_cnt: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(mark_out) |-> cnt_r == '0)
    else $error("mark started with stale count");

  chk_needs_pps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(mark_out) |-> $past(pps_in))
    else $error("mark started without second boundary");

  chk_len_legal: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_r == tmpe_pkg::TMPE_MARK)
      |-> (len_r == tmpe_pkg::CNT_W'(tmpe_pkg::MARK0_CYC)
           || len_r == tmpe_pkg::CNT_W'(tmpe_pkg::MARK1_CYC)))
    else $error("mark length not one of the two codes");

  chk_cnt_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_r == tmpe_pkg::TMPE_MARK) |-> cnt_r < len_r)
    else $error("mark count ran past its length");

  chk_len_keep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_r == tmpe_pkg::TMPE_MARK) |=> $stable(len_r))
    else $error("mark length changed mid mark");

  chk_mark_end: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_r == tmpe_pkg::TMPE_MARK && cnt_r == len_r - 1'b1) |=> !mark_out)
    else $error("mark not released at its length");

  chk_hi_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    hi_cnt_r < tmpe_pkg::CNT_W'(tmpe_pkg::MARK1_CYC))
    else $error("mark longer than a one bit");

  chk_gap_no_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(mark_out) |-> $past(sec_in) != tmpe_pkg::SEC_GAP)
    else $error("mark rose for the gap second");

  chk_gap_state: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pps_in && sec_in == tmpe_pkg::SEC_GAP && state_r == tmpe_pkg::TMPE_IDLE)
      |=> state_r == tmpe_pkg::TMPE_IDLE)
    else $error("gap second left idle");

  chk_head_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame[tmpe_pkg::POS_CALLBIT-1:tmpe_pkg::POS_START] == '0)
    else $error("frame head not zero");

  chk_time_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame[tmpe_pkg::POS_TIME_ST] == 1'b1)
    else $error("time start bit clear");

  chk_min_field: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame[tmpe_pkg::POS_MIN +: 7] == time_in.minute)
    else $error("minute field misplaced");

  chk_hour_field: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame[tmpe_pkg::POS_HOUR +: 6] == time_in.hour)
    else $error("hour field misplaced");

  chk_day_field: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame[tmpe_pkg::POS_DAY +: 6] == time_in.day)
    else $error("day field misplaced");

  chk_wday_field: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame[tmpe_pkg::POS_WDAY +: 3] == time_in.wday)
    else $error("weekday field misplaced");

  chk_year_field: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame[tmpe_pkg::POS_YEAR +: 8] == time_in.year)
    else $error("year field misplaced");

  chk_leap_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame[tmpe_pkg::POS_LEAP_ANN] == time_in.leap_ann)
    else $error("leap warning misplaced");

  chk_lost_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (push && !wr_ready) |=> frame_lost_out)
    else $error("lost frame not flagged");

  chk_lost_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame_lost_out |=> frame_lost_out)
    else $error("lost flag cleared without reset");

  chk_cur_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !pop |=> $stable(cur_r))
    else $error("current frame changed outside gap second");

  chk_ready_push: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (push && wr_ready) |=> frame_ready_out)
    else $error("queued frame not shown as ready");

endmodule

// *** tmpe_encoder_tb_top.sv ***
// Testbench for the time mark pulse encoder: reset, mark start, gap second, latch.
// Full mark lengths run to millions of cycles, so only their opening part is watched.
`timescale 1ns/1ps
module tmpe_encoder_tb_top;
  logic                 clk_in;
  logic                 rst_n_in;
  logic                 pps_in;
  logic [5:0]           sec_in;
  tmpe_pkg::tmpe_time_t time_in;
  logic                 frame_ready_out;
  logic                 frame_lost_out;
  logic                 mark_out;
  int unsigned          rises;
  int unsigned          hlen;
  int                   bad_count;
  int                   n_compared;

  tmpe_encoder u_dut (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .pps_in          (pps_in),
    .sec_in          (sec_in),
    .time_in         (time_in),
    .frame_ready_out (frame_ready_out),
    .frame_lost_out  (frame_lost_out),
    .mark_out        (mark_out)
  );

  tmpe_decoder_model u_rx (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .mark_in        (mark_out),
    .rise_count_out (rises),
    .high_len_out   (hlen)
  );

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic check1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One-cycle second boundary, then settle past the answering edge
  task automatic pulse(input logic [5:0] s);
    @(posedge clk_in);
    pps_in <= 1'b1;
    sec_in <= s;
    @(posedge clk_in);
    pps_in <= 1'b0;
    #1;
  endtask

  task automatic sc_reset_levels();
    check1("mark in reset", 1'b0, mark_out);
    check1("ready in reset", 1'b0, frame_ready_out);
    check1("lost in reset", 1'b0, frame_lost_out);
  endtask

  // A gap second before any mark: nothing may rise
  task automatic sc_gap();
    pulse(6'h3b);
    repeat (20) @(posedge clk_in);
    #1;
    check1("mark in gap", 1'b0, mark_out);
    check1("no rise in gap", 1'b1, rises == 0);
  endtask

  // First mark right after reset, no sync wait; extra pulse mid-mark refused
  task automatic sc_first_mark();
    pulse(6'h05);
    check1("mark rise", 1'b1, mark_out);
    repeat (2000) @(posedge clk_in);
    #1;
    check1("mark held", 1'b1, mark_out);
    pulse(6'h06);
    repeat (5) @(posedge clk_in);
    #1;
    check1("single rise", 1'b1, rises == 1);
    check1("mark still held", 1'b1, hlen > 2000);
  endtask

  task automatic sc_reset_mid();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    #1;
    check1("mark cleared", 1'b0, mark_out);
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
  endtask

  // Next minute is latched at second 58 and queued
  task automatic sc_latch();
    time_in <= '{minute: 7'h37, hour: 6'h23, day: 6'h31, wday: 3'h7, month: 5'h12,
                 year: 8'h99, dst_ann: 1'b1, dst_on: 1'b1, leap_ann: 1'b1, call_bit: 1'b0};
    pulse(6'h3a);
    check1("mark at 58", 1'b1, mark_out);
    check1("frame queued", 1'b1, frame_ready_out);
    check1("no loss", 1'b0, frame_lost_out);
  endtask

  // Gap second pops the queued minute into the current frame; the running mark goes on
  task automatic sc_pop();
    pulse(6'h3b);
    check1("queue drained", 1'b0, frame_ready_out);
    check1("mark kept at gap", 1'b1, mark_out);
    check1("minute field", 1'b1, u_dut.cur_r[27:21] == 7'h37);
    check1("minute parity", 1'b1, u_dut.cur_r[28]);
    check1("time start bit", 1'b1, u_dut.cur_r[20]);
    check1("summer bits", 1'b1, u_dut.cur_r[18:17] == 2'b01);
  endtask

  initial begin
    bad_count  = 0;
    n_compared = 0;
    rst_n_in   = 1'b0;
    pps_in     = 1'b0;
    sec_in     = 6'h00;
    time_in    = '0;
    repeat (10) @(posedge clk_in);
    sc_reset_levels();
    rst_n_in <= 1'b1;
    sc_gap();
    sc_first_mark();
    sc_reset_mid();
    sc_latch();
    sc_pop();
    report_and_stop();
  end
endmodule

// *** tmpe_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain; full and empty are exact.
`timescale 1ns/1ps
module tmpe_fifo #(
  parameter int unsigned WIDTH = 60,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  // Drain side
  output logic                  rd_valid_out,
  output logic [WIDTH-1:0]      rd_data_out,
  input  wire logic             rd_ready_in
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic [AW:0]      wp_nxt;
  logic [AW:0]      rp_nxt;
  logic             do_wr;
  logic             do_rd;

  always_comb begin
    wr_ready_out = (wp_r - rp_r) != (AW+1)'(DEPTH);
    rd_valid_out = wp_r != rp_r;
    rd_data_out  = mem_r[rp_r[AW-1:0]];
    do_wr        = wr_valid_in && wr_ready_out;
    do_rd        = rd_valid_out && rd_ready_in;
    wp_nxt       = do_wr ? wp_r + 1'b1 : wp_r;
    rp_nxt       = do_rd ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Storage has no reset; only pointers define validity
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem_r[wp_r[AW-1:0]] <= wr_data_in;
    end
  end

endmodule

// *** tmpe_pkg.sv ***
// Package for the time mark pulse encoder: constants, structs and states.
// Assumes a 125 MHz device clock and a one-pulse-per-second frame from on-chip logic.
package tmpe_pkg;

  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned MARK0_MS      = 100;
  localparam int unsigned MARK1_MS      = 200;
  localparam int unsigned MARK0_CYC     = CLK_HZ / 1000 * MARK0_MS;
  localparam int unsigned MARK1_CYC     = CLK_HZ / 1000 * MARK1_MS;
  localparam int unsigned CNT_W         = 25;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned FIFO_AW       = 4;
  localparam int unsigned FRAME_W       = 60;

  // Field positions within the minute frame
  localparam int unsigned POS_START     = 0;
  localparam int unsigned POS_CALLBIT   = 15;
  localparam int unsigned POS_DST_ANN   = 16;
  localparam int unsigned POS_DST_SUM   = 17;
  localparam int unsigned POS_DST_WIN   = 18;
  localparam int unsigned POS_LEAP_ANN  = 19;
  localparam int unsigned POS_TIME_ST   = 20;
  localparam int unsigned POS_MIN       = 21;
  localparam int unsigned POS_MIN_PAR   = 28;
  localparam int unsigned POS_HOUR      = 29;
  localparam int unsigned POS_HOUR_PAR  = 35;
  localparam int unsigned POS_DAY       = 36;
  localparam int unsigned POS_WDAY      = 42;
  localparam int unsigned POS_MON       = 45;
  localparam int unsigned POS_YEAR      = 50;
  localparam int unsigned POS_DATE_PAR  = 58;
  localparam int unsigned POS_GAP       = 59;
  localparam logic [5:0]  SEC_GAP       = 6'h3b;
  localparam logic [5:0]  SEC_LATCH     = 6'h3a;

  // Local time of the coming minute, all BCD
  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
    logic [5:0] day;
    logic [2:0] wday;
    logic [4:0] month;
    logic [7:0] year;
    logic       dst_ann;
    logic       dst_on;
    logic       leap_ann;
    logic       call_bit;
  } tmpe_time_t;

  typedef enum logic [1:0] {
    TMPE_IDLE = 2'b00,
    TMPE_MARK = 2'b01
  } tmpe_state_t;

endpackage
